// File: irq_ctrl_pkg.sv
// constants, register map and helpers for the four-level interrupt controller
package irq_ctrl_pkg;
    // ==========================================================
    // sizes
    localparam int SRC_N = 14;
    localparam int FLAG_W = 28;
    localparam int APB_AW = 8;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_ENABLE = 8'h04;
    localparam logic [7:0] OFS_PRIO_HIGH = 8'h08;
    localparam logic [7:0] OFS_PRIO_LOW = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_CORE = 8'h14;
    localparam logic [7:0] OFS_EVT = 8'h18;
    localparam logic [7:0] OFS_EVT_MASK = 8'h1C;
    // ==========================================================
    // field positions
    localparam int GLOBAL_EN_BIT = 15;
    localparam int CTRL_TRANS_A = 0;
    localparam int CTRL_TRANS_B = 1;
    localparam int CTRL_TRANS_C = 2;
    localparam int CTRL_TX_ROUTE = 3;
    localparam int CTRL_W = 4;
    localparam int EVT_W = 3;
    localparam int EVT_VECTORED = 0;
    localparam int EVT_NESTED = 1;
    localparam int EVT_RETURN = 2;
    // flag bit positions
    localparam int F_EXT_A = 0;
    localparam int F_TMR_A = 1;
    localparam int F_EXT_B = 2;
    localparam int F_TMR_B = 3;
    localparam int F_RX = 4;
    localparam int F_TX = 5;
    localparam int F_TMR_C_OVF = 6;
    localparam int F_TMR_C_EXT = 7;
    localparam int F_EXT_C = 8;
    localparam int F_SPI = 9;
    localparam int F_CONV = 10;
    localparam int F_CNT_OVF = 11;
    localparam int F_CNT_MOD_LO = 12;
    localparam int F_CNT_MOD_HI = 17;
    localparam int F_SYS_LO = 18;
    localparam int F_SYS_HI = 24;
    localparam int F_KEYPAD = 25;
    localparam int F_TWI = 26;
    localparam int F_CMP = 27;
    localparam logic [27:0] EXT_FLAG_MASK = 28'h000_0105;
    // ==========================================================
    // reset values
    localparam logic [27:0] FLAGS_RST = 28'h000_0000;
    localparam logic [13:0] SRC_RST = 14'h0000;
    localparam logic [15:0] VEC_RST = 16'h0000;
    // ==========================================================
    // vectors
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int VEC_STEP_SHIFT = 3;

    function automatic logic [15:0] vec_addr(input logic [3:0] idx);
        vec_addr = VEC_BASE + {9'h000, idx, 3'h0};
    endfunction : vec_addr

    // highest level currently in service
    function automatic logic [1:0] top_level(input logic [3:0] isr);
        top_level = isr[3] ? 2'd3 : isr[2] ? 2'd2 : isr[1] ? 2'd1 : 2'd0;
    endfunction : top_level
endpackage : irq_ctrl_pkg

// File: ext_pin_cond.sv
// external request pin conditioner: falling-edge pulse and active level
`timescale 1ns/10ps
module ext_pin_cond
    import irq_ctrl_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // pin and mode
    input wire logic i_pin_n,
    input wire logic i_trans_mode,
    // conditioned request
    output logic o_edge,
    output logic o_level
);
    typedef struct packed {
        logic prev_n;
    } cond_t;

    cond_t st_reg;
    cond_t st_next;

    always_comb begin
        st_next.prev_n = i_pin_n;
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '{prev_n: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_edge = i_trans_mode & st_reg.prev_n & ~i_pin_n;
    assign o_level = ~i_pin_n;
endmodule : ext_pin_cond

// File: prio_arbiter.sv
// four-level arbiter with fixed polling order inside a level
`timescale 1ns/10ps
module prio_arbiter
    import irq_ctrl_pkg::*;
(
    // requests and their levels
    input wire logic [SRC_N-1:0] i_req,
    input wire logic [SRC_N-1:0] i_prio_high,
    input wire logic [SRC_N-1:0] i_prio_low,
    // levels in service
    input wire logic [3:0] i_in_service,
    // winner
    output logic o_valid,
    output logic [3:0] o_idx,
    output logic [1:0] o_level
);
    always_comb begin
        o_valid = 1'b0;
        o_idx = 4'h0;
        o_level = 2'd0;
        // level 3 is scanned first; inside a level source 0 wins
        for (int lv = 3; lv >= 0; lv--) begin
            for (int s = 0; s < SRC_N; s++) begin
                if (!o_valid && i_req[s] && {i_prio_high[s], i_prio_low[s]} == 2'(lv)) begin // [RL2] [RL5] [RL12]
                    o_valid = 1'b1;
                    o_idx = 4'(s);
                    o_level = 2'(lv);
                end
            end
        end
        // only a strictly higher level pre-empts the routine in service
        if (|i_in_service && o_level <= top_level(i_in_service)) begin // [RL12]
            o_valid = 1'b0;
        end
    end
endmodule : prio_arbiter

// File: irq_ctrl_top.sv
// fourteen-source four-level interrupt controller with apb registers
// Operation
// [RL1] fourteen sources, each at one of four levels
// [RL2] level from priority-high bit and priority-low bit
// [RL3] request needs own enable and global enable
// [RL4] software writes set or clear every flag; in level mode the external flags take the pin and ignore the write
// [RL5] same level resolved by polling, source 0 first
// [RL6] vector address is 0003H plus eight times source
// [RL7] system source ORs watchdog, brownout, rtc, clock, bus
// [RL8] edge flags auto-clear on vectoring; level flags follow pin
// [RL9] serial and timer c flags cleared only by software
// [RL10] counter request ORs overflow and six module flags
// [RL11] transmit flag joins system source when routed
// [RL12] 11 highest; pre-empt only by higher; return reopens
`timescale 1ns/10ps
module irq_ctrl_top
    import irq_ctrl_pkg::*;
(
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [APB_AW-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // peripheral flag set pulses, bit layout as the flag register
    input wire logic [FLAG_W-1:0] I_FLAG_SET,
    // external request pins, active low
    input wire logic I_EXT_IRQ_PIN_A_N,
    input wire logic I_EXT_IRQ_PIN_B_N,
    input wire logic I_EXT_IRQ_PIN_C_N,
    // processor core
    input wire logic I_INT_ACK,
    input wire logic I_INT_RETURN,
    output logic O_INT_REQ,
    output logic [15:0] O_INT_VECTOR,
    output logic [1:0] O_INT_LEVEL,
    // event interrupt
    output logic O_IRQ
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [FLAG_W-1:0] flags_reg;
        logic [SRC_N-1:0] irq_enable_reg;
        logic global_irq_enable;
        logic [SRC_N-1:0] prio_high_reg;
        logic [SRC_N-1:0] prio_low_reg;
        logic [CTRL_W-1:0] ctrl_reg;
        logic [3:0] in_service_reg;
        logic [EVT_W-1:0] evt_reg;
        logic [EVT_W-1:0] evt_mask_reg;
        logic req_reg;
        logic [15:0] vec_reg;
        logic [3:0] src_reg;
        logic [1:0] lvl_reg;
        logic [31:0] prdata_reg;
        logic pready_reg;
        logic pslverr_reg;
        logic irq_reg;
    } state_t;

    state_t st_reg;
    state_t st_next;

    localparam state_t ST_RST = '{
        flags_reg: FLAGS_RST,
        irq_enable_reg: SRC_RST,
        global_irq_enable: 1'b0,
        prio_high_reg: SRC_RST,
        prio_low_reg: SRC_RST,
        ctrl_reg: '0,
        in_service_reg: 4'h0,
        evt_reg: '0,
        evt_mask_reg: '0,
        req_reg: 1'b0,
        vec_reg: VEC_RST,
        src_reg: 4'h0,
        lvl_reg: 2'd0,
        prdata_reg: 32'h0000_0000,
        pready_reg: 1'b0,
        pslverr_reg: 1'b0,
        irq_reg: 1'b0
    };

    // ==========================================================
    // external pins
    logic edge_a;
    logic edge_b;
    logic edge_c;
    logic lvl_a;
    logic lvl_b;
    logic lvl_c;

    ext_pin_cond u_ext_a (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_pin_n(I_EXT_IRQ_PIN_A_N),
        .i_trans_mode(st_reg.ctrl_reg[CTRL_TRANS_A]),
        .o_edge(edge_a),
        .o_level(lvl_a)
    );

    ext_pin_cond u_ext_b (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_pin_n(I_EXT_IRQ_PIN_B_N),
        .i_trans_mode(st_reg.ctrl_reg[CTRL_TRANS_B]),
        .o_edge(edge_b),
        .o_level(lvl_b)
    );

    ext_pin_cond u_ext_c (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_pin_n(I_EXT_IRQ_PIN_C_N),
        .i_trans_mode(st_reg.ctrl_reg[CTRL_TRANS_C]),
        .o_edge(edge_c),
        .o_level(lvl_c)
    );

    // ==========================================================
    // source requests
    logic [SRC_N-1:0] src_raw;
    logic [SRC_N-1:0] src_gated;
    logic [FLAG_W-1:0] f;

    always_comb begin
        f = st_reg.flags_reg;
        src_raw[0] = f[F_EXT_A];
        src_raw[1] = f[F_TMR_A];
        src_raw[2] = f[F_EXT_B];
        src_raw[3] = f[F_TMR_B];
        src_raw[4] = f[F_RX] | f[F_TX];
        src_raw[5] = f[F_TMR_C_OVF] | f[F_TMR_C_EXT];
        src_raw[6] = f[F_EXT_C];
        src_raw[7] = f[F_SPI];
        src_raw[8] = f[F_CONV];
        src_raw[9] = f[F_CNT_OVF] | (|f[F_CNT_MOD_HI:F_CNT_MOD_LO]); // [RL10]
        src_raw[10] = (|f[F_SYS_HI:F_SYS_LO]) // [RL7]
            | (st_reg.ctrl_reg[CTRL_TX_ROUTE] & f[F_TX]); // [RL11]
        src_raw[11] = f[F_KEYPAD];
        src_raw[12] = f[F_TWI];
        src_raw[13] = f[F_CMP];
        src_gated = src_raw & st_reg.irq_enable_reg & {SRC_N{st_reg.global_irq_enable}}; // [RL1] [RL3]
    end

    // ==========================================================
    // arbitration
    logic win_valid;
    logic [3:0] win_idx;
    logic [1:0] win_lvl;

    prio_arbiter u_arb (
        .i_req(src_gated),
        .i_prio_high(st_reg.prio_high_reg),
        .i_prio_low(st_reg.prio_low_reg),
        .i_in_service(st_reg.in_service_reg),
        .o_valid(win_valid),
        .o_idx(win_idx),
        .o_level(win_lvl)
    );

    // ==========================================================
    // next state
    logic acc_setup;
    logic acc_done;
    logic wr_done;
    logic rd_done;
    logic mapped;
    logic ack_ok;
    logic [FLAG_W-1:0] hw_set;
    logic [FLAG_W-1:0] hw_clr;
    logic [EVT_W-1:0] evt_in;
    logic [31:0] rd_val;

    always_comb begin
        st_next = st_reg;
        // apb: data is prepared in the wait cycle, the write lands on the
        // edge where the master sees pready, so every transfer has one wait
        acc_setup = I_PSEL & I_PENABLE & ~st_reg.pready_reg;
        acc_done = I_PSEL & I_PENABLE & st_reg.pready_reg;
        wr_done = acc_done & I_PWRITE & ~st_reg.pslverr_reg;
        rd_done = acc_done & ~I_PWRITE & ~st_reg.pslverr_reg;
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (I_PADDR)
            OFS_FLAGS: rd_val[FLAG_W-1:0] = st_reg.flags_reg;
            OFS_ENABLE: begin
                rd_val[SRC_N-1:0] = st_reg.irq_enable_reg;
                rd_val[GLOBAL_EN_BIT] = st_reg.global_irq_enable;
            end
            OFS_PRIO_HIGH: rd_val[SRC_N-1:0] = st_reg.prio_high_reg;
            OFS_PRIO_LOW: rd_val[SRC_N-1:0] = st_reg.prio_low_reg;
            OFS_CTRL: rd_val[CTRL_W-1:0] = st_reg.ctrl_reg;
            OFS_CORE: rd_val[7:0] = {st_reg.src_reg, st_reg.in_service_reg};
            OFS_EVT: rd_val[EVT_W-1:0] = st_reg.evt_reg;
            OFS_EVT_MASK: rd_val[EVT_W-1:0] = st_reg.evt_mask_reg;
            default: mapped = 1'b0;
        endcase
        st_next.pready_reg = acc_setup;
        if (acc_setup) begin
            st_next.prdata_reg = rd_val;
            st_next.pslverr_reg = ~mapped;
        end
        if (wr_done) begin
            unique case (I_PADDR)
                OFS_ENABLE: begin
                    st_next.irq_enable_reg = I_PWDATA[SRC_N-1:0];
                    st_next.global_irq_enable = I_PWDATA[GLOBAL_EN_BIT];
                end
                OFS_PRIO_HIGH: st_next.prio_high_reg = I_PWDATA[SRC_N-1:0]; // [RL2]
                OFS_PRIO_LOW: st_next.prio_low_reg = I_PWDATA[SRC_N-1:0]; // [RL2]
                OFS_CTRL: st_next.ctrl_reg = I_PWDATA[CTRL_W-1:0];
                OFS_EVT_MASK: st_next.evt_mask_reg = I_PWDATA[EVT_W-1:0];
                default: ;
            endcase
        end

        // core handshake: an ack only counts while a vector is presented
        ack_ok = I_INT_ACK & st_reg.req_reg;
        hw_clr = '0;
        if (ack_ok) begin
            unique case (st_reg.src_reg)
                4'd0: hw_clr[F_EXT_A] = st_reg.ctrl_reg[CTRL_TRANS_A]; // [RL8]
                4'd1: hw_clr[F_TMR_A] = 1'b1;
                4'd2: hw_clr[F_EXT_B] = st_reg.ctrl_reg[CTRL_TRANS_B]; // [RL8]
                4'd3: hw_clr[F_TMR_B] = 1'b1;
                4'd6: hw_clr[F_EXT_C] = st_reg.ctrl_reg[CTRL_TRANS_C]; // [RL8]
                default: ; // [RL9] [RL10]
            endcase
        end

        // flags: software write, then vector clear, then hardware set wins
        hw_set = (I_FLAG_SET & ~EXT_FLAG_MASK);
        hw_set[F_EXT_A] = edge_a;
        hw_set[F_EXT_B] = edge_b;
        hw_set[F_EXT_C] = edge_c;
        if (wr_done && I_PADDR == OFS_FLAGS) begin
            st_next.flags_reg = I_PWDATA[FLAG_W-1:0]; // [RL4]
        end
        st_next.flags_reg = (st_next.flags_reg & ~hw_clr) | hw_set;
        // level mode: the flag tracks the pin
        if (!st_reg.ctrl_reg[CTRL_TRANS_A]) begin
            st_next.flags_reg[F_EXT_A] = lvl_a; // [RL8]
        end
        if (!st_reg.ctrl_reg[CTRL_TRANS_B]) begin
            st_next.flags_reg[F_EXT_B] = lvl_b; // [RL8]
        end
        if (!st_reg.ctrl_reg[CTRL_TRANS_C]) begin
            st_next.flags_reg[F_EXT_C] = lvl_c; // [RL8]
        end

        // in-service levels
        if (I_INT_RETURN && |st_reg.in_service_reg) begin
            st_next.in_service_reg[top_level(st_reg.in_service_reg)] = 1'b0; // [RL12]
        end
        if (ack_ok) begin
            st_next.in_service_reg[st_reg.lvl_reg] = 1'b1; // [RL12]
        end

        // presented vector is withdrawn for one cycle after an ack so the
        // same source is not taken twice before in-service updates
        st_next.req_reg = win_valid & ~ack_ok & ~I_INT_RETURN;
        if (win_valid) begin
            st_next.vec_reg = vec_addr(win_idx); // [RL6]
            st_next.src_reg = win_idx;
            st_next.lvl_reg = win_lvl;
        end

        // sticky events, read clears, set wins over the clear
        evt_in = '0;
        evt_in[EVT_VECTORED] = ack_ok;
        evt_in[EVT_NESTED] = ack_ok & (|st_reg.in_service_reg);
        evt_in[EVT_RETURN] = I_INT_RETURN & (|st_reg.in_service_reg);
        if (rd_done && I_PADDR == OFS_EVT) begin
            st_next.evt_reg = evt_in;
        end else begin
            st_next.evt_reg = st_reg.evt_reg | evt_in;
        end
        st_next.irq_reg = |(st_next.evt_reg & st_next.evt_mask_reg);
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs
    assign O_PRDATA = st_reg.prdata_reg;
    assign O_PREADY = st_reg.pready_reg;
    assign O_PSLVERR = st_reg.pslverr_reg;
    assign O_INT_REQ = st_reg.req_reg;
    assign O_INT_VECTOR = st_reg.vec_reg;
    assign O_INT_LEVEL = st_reg.lvl_reg;
    assign O_IRQ = st_reg.irq_reg;
endmodule : irq_ctrl_top

// File: irq_ctrl_assertions.sv
// port checker for the four-level interrupt controller
`timescale 1ns/10ps
module irq_ctrl_assertions
    import irq_ctrl_pkg::*;
(
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    // apb
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    // core
    input wire logic I_INT_ACK,
    input wire logic I_INT_RETURN,
    input wire logic O_INT_REQ,
    input wire logic [15:0] O_INT_VECTOR,
    input wire logic [1:0] O_INT_LEVEL
);
    // ==========================================================
    // levels in service as seen from the core side
    logic [3:0] busy_reg;
    logic [3:0] busy_next;
    logic [2:0] top_c;
    always_comb begin
        top_c = 3'h4;
        for (int i = 0; i < 4; i++) begin
            if (busy_reg[i]) begin
                top_c = 3'(i);
            end
        end
        busy_next = busy_reg;
        if (I_INT_RETURN && top_c != 3'h4) begin
            busy_next[top_c[1:0]] = 1'b0;
        end
        if (I_INT_ACK && O_INT_REQ) begin
            busy_next[O_INT_LEVEL] = 1'b1;
        end
    end
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            busy_reg <= 4'h0;
        end else begin
            busy_reg <= busy_next;
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);
    sequence s_first_access;
        I_PSEL && I_PENABLE && !O_PREADY;
    endsequence
    sequence s_taken;
        O_INT_REQ && I_INT_ACK;
    endsequence
    chk_pready_wait: assert property (s_first_access |=> O_PREADY)
        else $error("ready not one cycle after access");
    chk_pready_pulse: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property ($rose(O_PSLVERR) |-> O_PREADY)
        else $error("error without ready");
    chk_rdata_hold: assert property (!O_PREADY && !(I_PSEL && I_PENABLE) |=> $stable(O_PRDATA))
        else $error("read data moved outside access");
    chk_vector_map: assert property (O_INT_REQ |-> O_INT_VECTOR[2:0] == 3'h3 && O_INT_VECTOR[15:7] == 9'h000 && O_INT_VECTOR[6:3] <= 4'hD)
        else $error("vector outside table");
    chk_ack_drop: assert property (s_taken |=> !O_INT_REQ)
        else $error("request held after ack");
    chk_ret_drop: assert property (I_INT_RETURN && top_c != 3'h4 |=> !O_INT_REQ)
        else $error("request held after return");
    chk_preempt_level: assert property (O_INT_REQ |-> top_c == 3'h4 || {1'b0, O_INT_LEVEL} > top_c)
        else $error("request not above level in service");
endmodule : irq_ctrl_assertions

bind irq_ctrl_top irq_ctrl_assertions u_chk (.I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_INT_ACK(I_INT_ACK), .I_INT_RETURN(I_INT_RETURN), .O_INT_REQ(O_INT_REQ),
    .O_INT_VECTOR(O_INT_VECTOR), .O_INT_LEVEL(O_INT_LEVEL));

// File: core_model.sv
// processor core model that takes vectors and returns from routines
`timescale 1ns/10ps
module core_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // bench commands
    input wire logic i_ack_go,
    input wire logic [3:0] i_delay,
    input wire logic i_ret_go,
    // controller side
    input wire logic i_req,
    output logic o_ack,
    output logic o_ret
);
    logic pend;
    logic [3:0] cnt;
    // ack only while a vector is presented, after a chosen stall
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pend <= 1'b0;
            cnt <= 4'h0;
            o_ack <= 1'b0;
            o_ret <= 1'b0;
        end else begin
            o_ack <= 1'b0;
            o_ret <= i_ret_go && !o_ret;
            if (i_ack_go) begin
                pend <= 1'b1;
            end
            if (pend && i_req && !o_ack) begin
                if (cnt == i_delay) begin
                    o_ack <= 1'b1;
                    pend <= 1'b0;
                    cnt <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule : core_model

// File: test_four_level_interrupt_controller.sv
// self-checking bench for the four-level interrupt controller
`timescale 1ns/10ps
module test_four_level_interrupt_controller
    import irq_ctrl_pkg::*;
;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [27:0] fset;
    logic pin_a, pin_b, pin_c, ack, ret, req, irq, ack_go, ret_go;
    logic [15:0] vec;
    logic [1:0] lvl;
    logic [3:0] dly;
    int fails, samples_checked, s;

    irq_ctrl_top dut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_FLAG_SET(fset), .I_EXT_IRQ_PIN_A_N(pin_a), .I_EXT_IRQ_PIN_B_N(pin_b),
        .I_EXT_IRQ_PIN_C_N(pin_c), .I_INT_ACK(ack), .I_INT_RETURN(ret), .O_INT_REQ(req),
        .O_INT_VECTOR(vec), .O_INT_LEVEL(lvl), .O_IRQ(irq));
    core_model core (.i_clk(clk), .i_nrst(nrst), .i_ack_go(ack_go), .i_delay(dly), .i_ret_go(ret_go),
        .i_req(req), .o_ack(ack), .o_ret(ret));

    task automatic give_verdict;
        if (fails == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bail(input int n);
        if (n >= 20) begin
            fails++;
            give_verdict();
        end
    endtask : bail
    // one apb transfer; an edge passes first so strobes never toggle twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        bail(n);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wreq(input logic [15:0] v, input logic [1:0] l);
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        while (req !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        bail(n);
        chk({13'h0, req, lvl, vec}, {13'h0, 1'b1, l, v});
    endtask : wreq
    task automatic noreq;
        repeat (3) @(posedge clk);
        chk({31'h0, req}, 32'h0000_0000);
    endtask : noreq
    task automatic core_do(input logic is_ret, input logic [3:0] d);
        int n;
        n = 0;
        dly <= d;
        ack_go <= !is_ret;
        ret_go <= is_ret;
        @(posedge clk);
        ack_go <= 1'b0;
        ret_go <= 1'b0;
        while (ack !== 1'b1 && ret !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        bail(n);
        repeat (2) @(posedge clk);
    endtask : core_do

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, fset, ack_go, ret_go, dly} = '0;
        {pin_a, pin_b, pin_c} = 3'h7;
        fails = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        // ==========================================================
        // reset values, then the unmapped slot refused
        for (int a = 0; a <= 32; a += 4) begin
            apb(1'b0, a[7:0], 32'h0000_0000);
            chk({rd[30:0], err}, {31'h0, a == 32});
        end
        apb(1'b1, OFS_ENABLE, 32'h0000_BFFF);
        apb(1'b1, OFS_CTRL, 32'h0000_0007);
        // ==========================================================
        // every flag bit reaches its own source and vector
        for (int b = 0; b < FLAG_W; b++) begin
            s = (b < 4) ? b : (b < 6) ? 4 : (b < 8) ? 5 : (b < 12) ? b - 2 : (b < 18) ? 9 : (b < 25) ? 10 : b - 14;
            if (EXT_FLAG_MASK[b]) apb(1'b1, OFS_FLAGS, 32'h1 << b);
            else begin
                fset <= 28'h1 << b;
                @(posedge clk);
                fset <= 28'h000_0000;
            end
            wreq(16'h0003 + 16'(s * 8), 2'h0);
            apb(1'b1, OFS_FLAGS, 32'h0000_0000);
            noreq();
        end
        // ==========================================================
        // polling order and the two priority bits
        apb(1'b1, OFS_FLAGS, 32'h0FFF_FFFF);
        wreq(16'h0003, 2'h0);
        apb(1'b1, OFS_PRIO_HIGH, 32'h0000_1000);
        apb(1'b1, OFS_PRIO_LOW, 32'h0000_2000);
        wreq(16'h0063, 2'h2);
        apb(1'b1, OFS_PRIO_HIGH, 32'h0000_3000);
        wreq(16'h006B, 2'h3);
        apb(1'b1, OFS_PRIO_HIGH, 32'h0000_3FFF);
        apb(1'b1, OFS_PRIO_LOW, 32'h0000_3FFF);
        wreq(16'h0003, 2'h3);
        apb(1'b1, OFS_PRIO_HIGH, 32'h0000_0000);
        apb(1'b1, OFS_PRIO_LOW, 32'h0000_0000);
        // ==========================================================
        // transmit flag joins the system source only when routed
        apb(1'b1, OFS_ENABLE, 32'h0000_BFEF);
        apb(1'b1, OFS_CTRL, 32'h0000_000F);
        apb(1'b1, OFS_FLAGS, 32'h0000_0020);
        wreq(16'h0053, 2'h0);
        apb(1'b1, OFS_CTRL, 32'h0000_0007);
        noreq();
        // ==========================================================
        // global and own enable both needed
        apb(1'b1, OFS_ENABLE, 32'h0000_3FFF);
        apb(1'b1, OFS_FLAGS, 32'h0000_0002);
        noreq();
        apb(1'b1, OFS_ENABLE, 32'h0000_BFFD);
        noreq();
        apb(1'b1, OFS_ENABLE, 32'h0000_BFFF);
        wreq(16'h000B, 2'h0);
        // ==========================================================
        // slow ack, same-level hold-off, nesting, events and returns
        apb(1'b1, OFS_EVT_MASK, 32'h0000_0001);
        core_do(1'b0, 4'h3);
        apb(1'b0, OFS_FLAGS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, OFS_FLAGS, 32'h0000_0010);
        noreq();
        apb(1'b1, OFS_PRIO_HIGH, 32'h0000_2000);
        apb(1'b1, OFS_PRIO_LOW, 32'h0000_2000);
        apb(1'b1, OFS_FLAGS, 32'h0800_0010);
        wreq(16'h006B, 2'h3);
        core_do(1'b0, 4'h0);
        apb(1'b0, OFS_EVT, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        apb(1'b0, OFS_FLAGS, 32'h0000_0000);
        chk(rd, 32'h0800_0010);
        chk({31'h0, irq}, 32'h0000_0000);
        core_do(1'b1, 4'h0);
        wreq(16'h006B, 2'h3);
        apb(1'b1, OFS_FLAGS, 32'h0000_0000);
        core_do(1'b1, 4'h0);
        apb(1'b0, OFS_EVT, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        // ==========================================================
        // pin b in level mode follows the pin; pin a edge clears on vectoring
        apb(1'b1, OFS_CTRL, 32'h0000_0005);
        pin_b <= 1'b0;
        apb(1'b0, OFS_FLAGS, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        pin_b <= 1'b1;
        apb(1'b0, OFS_FLAGS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        pin_a <= 1'b0;
        wreq(16'h0003, 2'h0);
        core_do(1'b0, 4'h1);
        apb(1'b0, OFS_FLAGS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        give_verdict();
    end
endmodule : test_four_level_interrupt_controller
